//--- pwmdcg_pkg.sv
/*
  Constants, register map and carrier types of the PWM duty cycle generator.
  Assumes an AXI4-Lite register bus with 32-bit data, one register per word.
*/
// Overview of operation
// - Period end: clear count, output active, buffer duties.
// - Zero duty keeps output inactive at boundary.
// - Postscaler never affects the PWM output.
// - Duty value is ten bits from two registers.
// - Upper eight bits high; low register bits 7:6.
// - Duty writes anytime; used after next boundary.
// - Active time equals duty times clock times prescale.
// - Two sub-count bits extend count to ten bits.
// - Prescale 1:1 advances time base every clock.
// - Duty steps equal four times limit plus one.
// - Full 1024 steps only when limit is 255.
// - Pulse wider than period leaves pin unchanged.
package pwmdcg_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] PWMDCG_ADDR_DUTY_UPPER  = 8'h00;
  localparam logic [7:0] PWMDCG_ADDR_DUTY_LOWER  = 8'h04;
  localparam logic [7:0] PWMDCG_ADDR_TIMER_LIMIT = 8'h08;
  localparam logic [7:0] PWMDCG_ADDR_CONTROL     = 8'h0c;
  localparam logic [7:0] PWMDCG_ADDR_STATUS      = 8'h10;
  localparam logic [7:0] PWMDCG_ADDR_COUNT       = 8'h14;

  localparam logic [7:0] PWMDCG_DUTY_UPPER_RST  = 8'h00;
  localparam logic [7:0] PWMDCG_DUTY_LOWER_RST  = 8'h00;
  localparam logic [7:0] PWMDCG_TIMER_LIMIT_RST = 8'hff;

  // Control register fields and the duty lower register field.
  localparam int PWMDCG_CTL_EN_BIT     = 0;
  localparam int PWMDCG_CTL_POL_BIT    = 1;
  localparam int PWMDCG_CTL_PRE_LSB    = 4;
  localparam int PWMDCG_CTL_POST_LSB   = 8;
  localparam int PWMDCG_LOWER_DUTY_LSB = 6;

  // Prescale codes: 1:1, 1:4, 1:16, 1:64.
  localparam logic [1:0] PWMDCG_PRE_1  = 2'h0;
  localparam logic [1:0] PWMDCG_PRE_4  = 2'h1;
  localparam logic [1:0] PWMDCG_PRE_16 = 2'h2;
  localparam logic [1:0] PWMDCG_PRE_64 = 2'h3;

  localparam logic [1:0] PWMDCG_RESP_OKAY   = 2'h0;
  localparam logic [1:0] PWMDCG_RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       enable;
    logic       polarity;
    logic [1:0] prescale;
    logic [3:0] postscale;
  } pwmdcg_ctl_s;

  typedef struct packed {
    logic [7:0] upper;
    logic [1:0] lower;
  } pwmdcg_duty_s;

  typedef enum logic [1:0] {
    PWMDCG_IDLE,
    PWMDCG_RESP
  } pwmdcg_bus_e;

endpackage

//--- pwmdcg_prescaler.sv
/*
  Prescaler of the period time base: emits one tick per prescale ratio.
  Assumes the control code is quasi static and the clock enable is shared.
*/
`timescale 1ns/10ps
module pwmdcg_prescaler
  import pwmdcg_pkg::*;
(
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       ce,
  // Control
  input  wire logic       run,
  input  wire logic [1:0] prescale,
  // Tick
  output logic            tick_q
);

  logic [5:0] div_q;
  logic [5:0] last;

  always_comb begin
    case (prescale)
      PWMDCG_PRE_1:  last = 6'h00;
      PWMDCG_PRE_4:  last = 6'h03;
      PWMDCG_PRE_16: last = 6'h0f;
      default:       last = 6'h3f;
    endcase
  end

  // The 1:1 code ticks on every enabled clock.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q  <= 6'h00;
      tick_q <= 1'b0;
    end else if (ce) begin
      if (!run) begin
        div_q  <= 6'h00;
        tick_q <= 1'b0;
      end else if (div_q >= last) begin
        div_q  <= 6'h00;
        tick_q <= 1'b1;
      end else begin
        div_q  <= div_q + 6'h01;
        tick_q <= 1'b0;
      end
    end
  end

endmodule

//--- pwmdcg_top.sv
/*
  PWM duty cycle generator with AXI4-Lite register access.
  Assumes one clock; the PWM output drives an external load.
*/
// The implementer's own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/10ps
module pwmdcg_top
  import pwmdcg_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // AXI4-Lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // PWM pin
  output logic             pwm_out_q
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [7:0]   pwm_duty_upper_bits_q;
  logic [7:0]   pwm_duty_lower_bits_q;
  logic [7:0]   period_timer_limit_q;
  pwmdcg_ctl_s  ctl_q;
  pwmdcg_duty_s duty_buf_q;
  logic [7:0]   period_timer_count_q;
  logic [1:0]   sub_count_q;
  logic         active_q;
  logic         period_flag_q;
  logic         tick;

  logic [7:0]   aw_addr_q;
  logic [31:0]  w_data_q;
  logic [3:0]   w_strb_q;
  logic         aw_held_q;
  logic         w_held_q;
  pwmdcg_bus_e  wr_state_q;
  pwmdcg_bus_e  rd_state_q;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == PWMDCG_ADDR_DUTY_UPPER) || (a == PWMDCG_ADDR_DUTY_LOWER) ||
             (a == PWMDCG_ADDR_TIMER_LIMIT) || (a == PWMDCG_ADDR_CONTROL) ||
             (a == PWMDCG_ADDR_STATUS) || (a == PWMDCG_ADDR_COUNT);
  endfunction

  // ----------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------
  logic wr_fire;
  assign wr_fire = aw_held_q && w_held_q && (wr_state_q == PWMDCG_IDLE);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q     <= 1'b0;
      w_held_q      <= 1'b0;
      aw_addr_q     <= 8'h00;
      w_data_q      <= 32'h0000_0000;
      w_strb_q      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= PWMDCG_RESP_OKAY;
      wr_state_q    <= PWMDCG_IDLE;
    end else if (ce) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      if (s_axi_awvalid && !aw_held_q && !s_axi_awready) begin
        s_axi_awready <= 1'b1;
        aw_held_q     <= 1'b1;
        aw_addr_q     <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held_q && !s_axi_wready) begin
        s_axi_wready <= 1'b1;
        w_held_q     <= 1'b1;
        w_data_q     <= s_axi_wdata;
        w_strb_q     <= s_axi_wstrb;
      end
      case (wr_state_q)
        PWMDCG_IDLE: begin
          if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= mapped(aw_addr_q) ? PWMDCG_RESP_OKAY : PWMDCG_RESP_SLVERR;
            wr_state_q   <= PWMDCG_RESP;
          end
        end
        PWMDCG_RESP: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_held_q    <= 1'b0;
            w_held_q     <= 1'b0;
            wr_state_q   <= PWMDCG_IDLE;
          end
        end
        default: wr_state_q <= PWMDCG_IDLE;
      endcase
    end
  end

  // Duty registers accept writes at any time; the generator reads them only at a period end.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwm_duty_upper_bits_q <= PWMDCG_DUTY_UPPER_RST;
      pwm_duty_lower_bits_q <= PWMDCG_DUTY_LOWER_RST;
      period_timer_limit_q  <= PWMDCG_TIMER_LIMIT_RST;
      ctl_q                 <= '0;
    end else if (ce && wr_fire) begin
      if (w_strb_q[0]) begin
        case (aw_addr_q)
          PWMDCG_ADDR_DUTY_UPPER:  pwm_duty_upper_bits_q <= w_data_q[7:0];
          PWMDCG_ADDR_DUTY_LOWER:  pwm_duty_lower_bits_q <= w_data_q[7:0];
          PWMDCG_ADDR_TIMER_LIMIT: period_timer_limit_q  <= w_data_q[7:0];
          PWMDCG_ADDR_CONTROL: begin
            ctl_q.enable   <= w_data_q[PWMDCG_CTL_EN_BIT];
            ctl_q.polarity <= w_data_q[PWMDCG_CTL_POL_BIT];
            ctl_q.prescale <= w_data_q[PWMDCG_CTL_PRE_LSB +: 2];
          end
          default: ctl_q <= ctl_q;
        endcase
      end
      // The postscale field sits in byte lane one, so it follows its own strobe.
      if (w_strb_q[1] && (aw_addr_q == PWMDCG_ADDR_CONTROL)) begin
        ctl_q.postscale <= w_data_q[PWMDCG_CTL_POST_LSB +: 4];
      end
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  function automatic logic [31:0] read_word(input logic [7:0] a);
    case (a)
      PWMDCG_ADDR_DUTY_UPPER:  read_word = {24'h000000, pwm_duty_upper_bits_q};
      PWMDCG_ADDR_DUTY_LOWER:  read_word = {24'h000000, pwm_duty_lower_bits_q};
      PWMDCG_ADDR_TIMER_LIMIT: read_word = {24'h000000, period_timer_limit_q};
      PWMDCG_ADDR_CONTROL:     read_word = {20'h00000, ctl_q.postscale, 2'h0, ctl_q.prescale,
                                            2'h0, ctl_q.polarity, ctl_q.enable};
      PWMDCG_ADDR_STATUS:      read_word = {20'h00000, duty_buf_q, active_q, period_flag_q};
      PWMDCG_ADDR_COUNT:       read_word = {22'h0, period_timer_count_q, sub_count_q};
      default:                 read_word = 32'h0000_0000;
    endcase
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= PWMDCG_RESP_OKAY;
      rd_state_q    <= PWMDCG_IDLE;
    end else if (ce) begin
      s_axi_arready <= 1'b0;
      case (rd_state_q)
        PWMDCG_IDLE: begin
          if (s_axi_arvalid && !s_axi_arready) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= read_word(s_axi_araddr);
            s_axi_rresp   <= mapped(s_axi_araddr) ? PWMDCG_RESP_OKAY : PWMDCG_RESP_SLVERR;
            rd_state_q    <= PWMDCG_RESP;
          end
        end
        PWMDCG_RESP: begin
          if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            rd_state_q   <= PWMDCG_IDLE;
          end
        end
        default: rd_state_q <= PWMDCG_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Time base
  // ----------------------------------------------------------------
  // The postscale field is held for software only and feeds nothing here.
  pwmdcg_prescaler u_prescaler (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .ce       (ce),
    .run      (ctl_q.enable),
    .prescale (ctl_q.prescale),
    .tick_q   (tick)
  );

  logic       period_end;
  logic [9:0] time_base;
  logic [9:0] duty_new;
  assign time_base  = {period_timer_count_q, sub_count_q};
  // A tick still in flight from before a disable must not end a period.
  assign period_end = ctl_q.enable && tick && (sub_count_q == 2'h3) &&
                      (period_timer_count_q == period_timer_limit_q);
  assign duty_new   = {pwm_duty_upper_bits_q,
                       pwm_duty_lower_bits_q[PWMDCG_LOWER_DUTY_LSB +: 2]};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      period_timer_count_q <= 8'h00;
      sub_count_q          <= 2'h0;
      duty_buf_q           <= '0;
      period_flag_q        <= 1'b0;
    end else if (ce) begin
      period_flag_q <= period_end;
      if (!ctl_q.enable) begin
        period_timer_count_q <= 8'h00;
        sub_count_q          <= 2'h0;
      end else if (period_end) begin
        period_timer_count_q <= 8'h00;
        sub_count_q          <= 2'h0;
        duty_buf_q           <= duty_new;
      end else if (tick) begin
        sub_count_q <= sub_count_q + 2'h1;
        if (sub_count_q == 2'h3) begin
          period_timer_count_q <= period_timer_count_q + 8'h01;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Output stage
  // ----------------------------------------------------------------
  // A duty past the period never matches, so the pin holds its level.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      active_q <= 1'b0;
    end else if (ce) begin
      if (!ctl_q.enable) begin
        active_q <= 1'b0;
      end else if (period_end) begin
        active_q <= (duty_new != 10'h000);
      end else if (tick && (time_base + 10'h001 == duty_buf_q)) begin
        active_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwm_out_q <= 1'b0;
    end else if (ce) begin
      pwm_out_q <= active_q ^ ctl_q.polarity;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_period_clear;
    @(posedge aclk) disable iff (!aresetn)
      (ce && period_end) |=> (period_timer_count_q == 8'h00 && sub_count_q == 2'h0);
  endproperty
  a_period_clear: assert property (p_period_clear) else $error("count not cleared at period end");

  property p_buffer_load;
    @(posedge aclk) disable iff (!aresetn)
      (ce && period_end) |=> (duty_buf_q == $past(duty_new));
  endproperty
  a_buffer_load: assert property (p_buffer_load) else $error("duty buffer not loaded");

  property p_zero_duty;
    @(posedge aclk) disable iff (!aresetn)
      (ce && period_end && duty_new == 10'h000) |=> !active_q;
  endproperty
  a_zero_duty: assert property (p_zero_duty) else $error("zero duty went active");

  property p_active_start;
    @(posedge aclk) disable iff (!aresetn)
      (ce && period_end && duty_new != 10'h000) |=> active_q;
  endproperty
  a_active_start: assert property (p_active_start) else $error("output not active at period start");

  property p_buffer_hold;
    @(posedge aclk) disable iff (!aresetn)
      !period_end |=> $stable(duty_buf_q);
  endproperty
  a_buffer_hold: assert property (p_buffer_hold) else $error("duty buffer changed mid period");

  property p_match_off;
    @(posedge aclk) disable iff (!aresetn)
      (ce && ctl_q.enable && tick && !period_end && time_base + 10'h001 == duty_buf_q) |=> !active_q;
  endproperty
  a_match_off: assert property (p_match_off) else $error("output not released at match");

  property p_count_bound;
    @(posedge aclk) disable iff (!aresetn)
      (period_timer_count_q <= period_timer_limit_q) || $changed(period_timer_limit_q) ||
      $past(period_timer_count_q > period_timer_limit_q);
  endproperty
  a_count_bound: assert property (p_count_bound) else $error("count ran past limit");

  property p_fast_tick;
    @(posedge aclk) disable iff (!aresetn)
      (ce && ctl_q.enable && ctl_q.prescale == PWMDCG_PRE_1 && $past(ctl_q.enable) && $past(ce) &&
       $past(ctl_q.prescale) == PWMDCG_PRE_1) |-> tick;
  endproperty
  a_fast_tick: assert property (p_fast_tick) else $error("1:1 prescale missed a tick");

  property p_steady;
    @(posedge aclk) disable iff (!aresetn)
      (ce && !tick && !period_end && $stable(ctl_q.enable)) |=> $stable(active_q);
  endproperty
  a_steady: assert property (p_steady) else $error("output moved without a tick");

  property p_count_step;
    @(posedge aclk) disable iff (!aresetn)
      (ce && ctl_q.enable && tick && !period_end) |=> (time_base == $past(time_base) + 10'h001);
  endproperty
  a_count_step: assert property (p_count_step) else $error("time base did not step by one");

  property p_pin_follow;
    @(posedge aclk) disable iff (!aresetn)
      ce |=> (pwm_out_q == ($past(active_q) ^ $past(ctl_q.polarity)));
  endproperty
  a_pin_follow: assert property (p_pin_follow) else $error("pin does not follow active level");

  c_period: cover property (@(posedge aclk) disable iff (!aresetn) period_end);
  c_match:  cover property (@(posedge aclk) disable iff (!aresetn) active_q ##1 !active_q);
  c_write:  cover property (@(posedge aclk) disable iff (!aresetn) wr_fire);
  c_zero:   cover property (@(posedge aclk) disable iff (!aresetn) period_end && duty_new == 10'h000);

endmodule

//--- pwmdcg_load_model.sv
/*
  Behavioural load on the PWM pin: measures pulse length, period and high time.
  Assumes the pin is sampled on the rising edge of the block clock.
*/
`timescale 1ns/10ps
module pwmdcg_load_model (
  // Clock
  input  wire logic   aclk,
  // Pin and control
  input  wire logic   pwm_in,
  input  wire logic   clr_hi,
  // Measurements
  output logic [15:0] hi_len_q,
  output logic [15:0] per_len_q,
  output logic [15:0] hi_cnt_q
);
  logic        pin_q        = 1'b0;
  logic [15:0] since_rise_q = 16'h0000;

  always @(posedge aclk) begin
    pin_q        <= pwm_in;
    since_rise_q <= (pwm_in && !pin_q) ? 16'h0001 : since_rise_q + 16'h0001;
    if (pwm_in && !pin_q) begin
      per_len_q <= since_rise_q;
    end
    if (!pwm_in && pin_q) begin
      hi_len_q <= since_rise_q;
    end
    hi_cnt_q <= clr_hi ? 16'h0000 : hi_cnt_q + {15'h0, pwm_in};
  end
endmodule

//--- pwm_duty_cycle_generator_test.sv
/*
  Self-checking bench of the PWM duty cycle generator.
  Assumes the design answers on AXI4-Lite and the load model measures the pin.
*/
`timescale 1ns/10ps
module pwm_duty_cycle_generator_test;
  import pwmdcg_pkg::*;

  logic        aclk    = 1'b0;
  logic        aresetn = 1'b0;
  logic        ce      = 1'b1;
  logic [7:0]  awaddr  = 8'h00;
  logic        awvalid = 1'b0;
  logic        awready;
  logic [31:0] wdata   = 32'h0;
  logic        wvalid  = 1'b0;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready  = 1'b0;
  logic [7:0]  araddr  = 8'h00;
  logic        arvalid = 1'b0;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready  = 1'b0;
  logic        pwm;
  logic        clr_hi  = 1'b0;
  logic [15:0] hi_len;
  logic [15:0] per_len;
  logic [15:0] hi_cnt;
  int          num_errors = 0;
  int          tests_run  = 0;
  int          cyc        = 0;
  logic [31:0] d;
  logic [1:0]  r;
  logic [7:0]  lim_t [7] = '{8'h03, 8'h03, 8'h03, 8'h03, 8'h01, 8'h03, 8'hff};
  logic [7:0]  up_t  [7] = '{8'h01, 8'h01, 8'h02, 8'h00, 8'h01, 8'h01, 8'hff};
  logic [7:0]  lo_t  [7] = '{8'h80, 8'h80, 8'h40, 8'h40, 8'hc0, 8'h80, 8'hc0};
  logic [11:0] ctl_t [7] = '{12'h001, 12'h011, 12'hf11, 12'h031, 12'h021, 12'h003, 12'h001};

  always #4 aclk = ~aclk;

  pwmdcg_top u_dut (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pwm_out_q(pwm)
  );

  pwmdcg_load_model u_load (
    .aclk(aclk), .pwm_in(pwm), .clr_hi(clr_hi),
    .hi_len_q(hi_len), .per_len_q(per_len), .hi_cnt_q(hi_cnt)
  );

  // ----------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic axi_wr(input logic [7:0] addr, input logic [31:0] data, input logic [1:0] exp);
    @(posedge aclk);
    awaddr  <= addr;
    wdata   <= data;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", {30'h0, bresp}, {30'h0, exp});
  endtask

  task automatic axi_rd(input logic [7:0] addr, output logic [31:0] data, output logic [1:0] resp);
    @(posedge aclk);
    araddr  <= addr;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    data = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  task automatic rd_chk(input string name, input logic [7:0] addr, input logic [31:0] exp);
    logic [31:0] v;
    logic [1:0]  s;
    axi_rd(addr, v, s);
    chk(name, v, exp);
  endtask

  task automatic setup(input logic [7:0] lim, input logic [7:0] up, input logic [7:0] lo,
                       input logic [11:0] ctl);
    axi_wr(PWMDCG_ADDR_CONTROL, 32'h0, PWMDCG_RESP_OKAY);
    axi_wr(PWMDCG_ADDR_TIMER_LIMIT, {24'h0, lim}, PWMDCG_RESP_OKAY);
    axi_wr(PWMDCG_ADDR_DUTY_UPPER, {24'h0, up}, PWMDCG_RESP_OKAY);
    axi_wr(PWMDCG_ADDR_DUTY_LOWER, {24'h0, lo}, PWMDCG_RESP_OKAY);
    axi_wr(PWMDCG_ADDR_CONTROL, {20'h0, ctl}, PWMDCG_RESP_OKAY);
  endtask

  task automatic high_over(input int n, input logic [15:0] exp);
    clr_hi <= 1'b1;
    @(posedge aclk);
    clr_hi <= 1'b0;
    repeat (n) @(posedge aclk);
    #1;
    chk("high_cycles", {16'h0, hi_cnt}, {16'h0, exp});
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  always @(posedge aclk) begin
    cyc++;
    if (cyc == 40000) begin
      num_errors++;
      $display("timeout after %0d cycles", cyc);
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    int unsigned pre;
    int unsigned duty;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk("duty_upper_rst", PWMDCG_ADDR_DUTY_UPPER, {24'h0, PWMDCG_DUTY_UPPER_RST});
    rd_chk("duty_lower_rst", PWMDCG_ADDR_DUTY_LOWER, {24'h0, PWMDCG_DUTY_LOWER_RST});
    rd_chk("limit_rst", PWMDCG_ADDR_TIMER_LIMIT, {24'h0, PWMDCG_TIMER_LIMIT_RST});
    axi_rd(8'h18, d, r);
    chk("unmapped_rdata", d, 32'h0);
    chk("unmapped_rresp", {30'h0, r}, {30'h0, PWMDCG_RESP_SLVERR});
    axi_wr(8'h1c, 32'h0000_00ff, PWMDCG_RESP_SLVERR);
    $display("test registers done");
    // Every prescale code, a postscale setting, inverted polarity and the full resolution case.
    for (int i = 0; i < 7; i++) begin
      pre  = 1 << (2 * ctl_t[i][5:4]);
      duty = {up_t[i], lo_t[i][7:6]};
      setup(lim_t[i], up_t[i], lo_t[i], ctl_t[i]);
      rd_chk("duty_upper", PWMDCG_ADDR_DUTY_UPPER, {24'h0, up_t[i]});
      rd_chk("control", PWMDCG_ADDR_CONTROL, {20'h0, ctl_t[i]});
      repeat (3 * 4 * (lim_t[i] + 1) * pre + 8) @(posedge aclk);
      chk("period", {16'h0, per_len}, 4 * (lim_t[i] + 1) * pre);
      chk("pulse", {16'h0, hi_len}, ctl_t[i][1] ? 4 * (lim_t[i] + 1) * pre - duty * pre : duty * pre);
      $display("test timing %0d done", i);
    end
    // The buffer keeps the last full-resolution duty until the first boundary.
    setup(8'h03, 8'h00, 8'h00, 12'h001);
    rd_chk("status_old_buffer", PWMDCG_ADDR_STATUS, 32'h0000_0ffc);
    repeat (20) @(posedge aclk);
    high_over(100, 16'd0);
    axi_rd(PWMDCG_ADDR_STATUS, d, r);
    chk("status_new_buffer", {22'h0, d[11:2]}, 32'h0);
    $display("test zero duty done");
    // A low clock enable freezes the generator before its first boundary.
    setup(8'h03, 8'h05, 8'h00, 12'h001);
    ce <= 1'b0;
    high_over(100, 16'd0);
    @(posedge aclk);
    ce <= 1'b1;
    repeat (20) @(posedge aclk);
    high_over(100, 16'd100);
    $display("test wide duty done");
    tally_and_finish();
  end
endmodule
